// ===== accel_defines.svh
// Shared constants for the accelerometer mode and rate control ends
`ifndef ACCEL_DEFINES_SVH
`define ACCEL_DEFINES_SVH
`define CLOCK_HZ 25000000
`define HZ_PER_KHZ 1000
`define HZ_PER_MHZ 1000000
`define BOOT_TIME_MS 5
`define LP_ON_TIME_US 1000
`define NORMAL_ON_TIME_US 1600
`define HIGH_RES_ON_PERIODS 7
`define ADDR_CONTROL_ONE 8'h20
`define ADDR_CONTROL_TWO 8'h21
`define ADDR_CONTROL_THREE 8'h22
`define ADDR_CONTROL_FOUR 8'h23
`define ADDR_CONTROL_SIX 8'h25
`define ADDR_REFERENCE 8'h26
`define ADDR_OUT_X_L 8'h28
`define ADDR_OUT_X_H 8'h29
`define ADDR_OUT_Y_L 8'h2a
`define ADDR_OUT_Y_H 8'h2b
`define ADDR_OUT_Z_L 8'h2c
`define ADDR_OUT_Z_H 8'h2d
`define ADDR_IRQ_GEN_A 8'h30
`define ADDR_IRQ_GEN_B 8'h34
`define LOW_POWER_BIT 3
`define HIGH_RES_BIT 3
`define RATE_MSB 7
`define RATE_LSB 4
`define X_EN_BIT 0
`define Y_EN_BIT 1
`define Z_EN_BIT 2
`define ROUTE_GEN_A_BIT 6
`define ROUTE_GEN_B_BIT 5
`define POLARITY_BIT 1
`define ALL_EVENTS_BIT 7
`define RATE_POWER_DOWN 4'h0
`define REG_RESET 8'h00
`define SW_COMMAND 8'h00
`define SW_TARGET 8'h01
`define SW_WDATA 8'h02
`define SW_RDATA 8'h03
`define SW_STATUS 8'h04
`define SW_IRQ_STATUS 8'h05
`define SW_IRQ_MASK 8'h06
`define CMD_WRITE 0
`define CMD_READ 1
`define CMD_RECOVER 2
`define RECOVER_HIGH_RES 8'h08
`define RECOVER_ON 8'h57
`define RECOVER_OFF 8'h07
`define EV_DONE 0
`define EV_PIN_A 1
`define EV_PIN_B 2
`define EV_REFUSED 3
`endif

// ===== accel_device.sv
// Sensor device end: boot, mode and rate decode, sampling, register file
// Contract
// - Boot about 5 ms, then power-down.
// - Low-power and high-resolution bits choose mode.
// - Low-power mode gives 8-bit samples.
// - Normal mode gives 10-bit samples.
// - High-resolution mode gives 12-bit samples.
// - Rate code zero off, one to seven rates.
// - Codes eight and nine give mode-dependent fast rates.
// - Power-down keeps configuration and host interface.
// - Power-down freezes last output samples.
// - Disabled axes output zero; enabled sample.
// - Samples left-aligned in output registers.
// - Interrupt generators routable to both pins.
// - Reference read resets filter block.
// - Host waits turn-on time after enabling.
// - Host recovery sequence through power-down.
`include "accel_defines.svh"
`default_nettype none
module accel_device #(
	parameter int unsigned CLOCK_HZ = `CLOCK_HZ,
	parameter int unsigned BOOT_CYCLES = `BOOT_TIME_MS * (CLOCK_HZ / `HZ_PER_KHZ)
) (
	input wire logic clk,
	input wire logic reset_n,
	accel_link_if.device link,
	input wire logic [15:0] accel_x,
	input wire logic [15:0] accel_y,
	input wire logic [15:0] accel_z,
	output logic booting,
	output accel_pkg::mode_type active_mode,
	output logic sampling,
	output logic sample_strobe,
	output logic filter_reset
);
	import accel_pkg::*;
	typedef struct packed {
		dev_state_type phase;
		logic [31:0] boot_count;
		logic [7:0] control_one;
		logic [7:0] control_two;
		logic [7:0] control_three;
		logic [7:0] control_four;
		logic [7:0] control_six;
		logic [7:0] reference;
		logic [7:0] gen_a_cfg;
		logic [7:0] gen_b_cfg;
		logic [15:0] out_x;
		logic [15:0] out_y;
		logic [15:0] out_z;
		logic gen_a;
		logic gen_b;
		logic pin_a;
		logic pin_b;
		logic [7:0] rdata;
		mode_type mode;
		logic booting;
		logic sampling;
		logic sample_strobe;
		logic filter_reset;
	} device_type;
	device_type state, next_state;
	mode_type mode;
	logic tick;
	logic [3:0] rate_code;
	logic lp;
	logic active_ok;
	logic hit_a;
	logic hit_b;
	logic route_a;
	logic route_b;

	// High event beyond half scale positive, low event beyond half scale negative
	function automatic logic gen_hit(input logic [7:0] cfg, input logic [15:0] x,
		input logic [15:0] y, input logic [15:0] z);
		logic [5:0] ev;
		logic [5:0] en;
		ev = {~z[15] & z[14], z[15] & ~z[14], ~y[15] & y[14], y[15] & ~y[14],
			~x[15] & x[14], x[15] & ~x[14]};
		en = cfg[5:0];
		if (cfg[`ALL_EVENTS_BIT])
			return (|en) && (&(ev | ~en));
		return |(ev & en);
	endfunction

	rate_ticker #(.CLOCK_HZ(CLOCK_HZ)) ticker (
		.clk(clk),
		.reset_n(reset_n),
		.run(state.phase == SAMPLING),
		.rate_code(rate_code),
		.low_power(lp),
		.tick(tick)
	);

	always_comb
	begin
		lp = state.control_one[`LOW_POWER_BIT];
		rate_code = state.control_one[`RATE_MSB:`RATE_LSB];
		mode = decode_mode(lp, state.control_four[`HIGH_RES_BIT]);
		// Codes with no rate in this mode behave as power-down
		active_ok = (rate_code != `RATE_POWER_DOWN) && (rate_hz(rate_code, lp) != 0)
			&& (mode != MODE_FORBIDDEN);
		next_state = state;
		next_state.sample_strobe = 1'b0;
		next_state.filter_reset = 1'b0;
		next_state.mode = mode;

		if (state.phase == BOOTING)
		begin
			if (state.boot_count >= 32'(BOOT_CYCLES) - 32'h1)
				next_state.phase = POWERED_DOWN;
			else
				next_state.boot_count = state.boot_count + 32'h1;
		end
		else
			next_state.phase = active_ok ? SAMPLING : POWERED_DOWN;

		// The link stays live in every phase and nothing clears the setup
		if (link.wr)
		begin
			case (link.addr)
				`ADDR_CONTROL_ONE: next_state.control_one = link.wdata;
				`ADDR_CONTROL_TWO: next_state.control_two = link.wdata;
				`ADDR_CONTROL_THREE: next_state.control_three = link.wdata;
				`ADDR_CONTROL_FOUR: next_state.control_four = link.wdata;
				`ADDR_CONTROL_SIX: next_state.control_six = link.wdata;
				`ADDR_REFERENCE: next_state.reference = link.wdata;
				`ADDR_IRQ_GEN_A: next_state.gen_a_cfg = link.wdata;
				`ADDR_IRQ_GEN_B: next_state.gen_b_cfg = link.wdata;
				default: ;
			endcase
		end

		next_state.rdata = 8'h00;
		if (link.rd)
		begin
			case (link.addr)
				`ADDR_CONTROL_ONE: next_state.rdata = state.control_one;
				`ADDR_CONTROL_TWO: next_state.rdata = state.control_two;
				`ADDR_CONTROL_THREE: next_state.rdata = state.control_three;
				`ADDR_CONTROL_FOUR: next_state.rdata = state.control_four;
				`ADDR_CONTROL_SIX: next_state.rdata = state.control_six;
				`ADDR_REFERENCE:
				begin
					next_state.rdata = state.reference;
					next_state.filter_reset = 1'b1;
				end
				`ADDR_OUT_X_L: next_state.rdata = state.out_x[7:0];
				`ADDR_OUT_X_H: next_state.rdata = state.out_x[15:8];
				`ADDR_OUT_Y_L: next_state.rdata = state.out_y[7:0];
				`ADDR_OUT_Y_H: next_state.rdata = state.out_y[15:8];
				`ADDR_OUT_Z_L: next_state.rdata = state.out_z[7:0];
				`ADDR_OUT_Z_H: next_state.rdata = state.out_z[15:8];
				`ADDR_IRQ_GEN_A: next_state.rdata = state.gen_a_cfg;
				`ADDR_IRQ_GEN_B: next_state.rdata = state.gen_b_cfg;
				default: next_state.rdata = 8'h00;
			endcase
		end

		// Outputs only move on a tick while sampling, so power-down holds them
		if (tick && state.phase == SAMPLING && active_ok)
		begin
			next_state.sample_strobe = 1'b1;
			next_state.out_x = state.control_one[`X_EN_BIT]
				? (accel_x & sample_mask(mode)) : 16'h0000;
			next_state.out_y = state.control_one[`Y_EN_BIT]
				? (accel_y & sample_mask(mode)) : 16'h0000;
			next_state.out_z = state.control_one[`Z_EN_BIT]
				? (accel_z & sample_mask(mode)) : 16'h0000;
			next_state.gen_a = gen_hit(state.gen_a_cfg, next_state.out_x,
				next_state.out_y, next_state.out_z);
			next_state.gen_b = gen_hit(state.gen_b_cfg, next_state.out_x,
				next_state.out_y, next_state.out_z);
		end
		// A filter reset also drops pending generator flags
		if (next_state.filter_reset)
		begin
			next_state.gen_a = 1'b0;
			next_state.gen_b = 1'b0;
		end

		hit_a = next_state.gen_a;
		hit_b = next_state.gen_b;
		route_a = (next_state.control_three[`ROUTE_GEN_A_BIT] & hit_a)
			| (next_state.control_three[`ROUTE_GEN_B_BIT] & hit_b);
		route_b = (next_state.control_six[`ROUTE_GEN_A_BIT] & hit_a)
			| (next_state.control_six[`ROUTE_GEN_B_BIT] & hit_b);
		next_state.pin_a = route_a ^ next_state.control_six[`POLARITY_BIT];
		next_state.pin_b = route_b ^ next_state.control_six[`POLARITY_BIT];

		next_state.booting = (next_state.phase == BOOTING);
		next_state.sampling = (next_state.phase == SAMPLING);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= '0;
			state.phase <= BOOTING;
			state.booting <= 1'b1;
			state.mode <= MODE_NORMAL;
			state.control_one <= `REG_RESET;
			state.control_four <= `REG_RESET;
		end
		else
			state <= next_state;
	end

	assign link.rdata = state.rdata;
	assign link.irq_pin_a = state.pin_a;
	assign link.irq_pin_b = state.pin_b;
	assign booting = state.booting;
	assign active_mode = state.mode;
	assign sampling = state.sampling;
	assign sample_strobe = state.sample_strobe;
	assign filter_reset = state.filter_reset;
endmodule // accel_device
`default_nettype wire

// ===== accel_host.sv
// Host controller end: software registers, link transfers, turn-on wait, recovery
//
// Our own choice: the strobed register port.
`include "accel_defines.svh"
`default_nettype none
module accel_host #(
	parameter int unsigned CLOCK_HZ = `CLOCK_HZ,
	parameter int unsigned LP_ON_CYCLES = `LP_ON_TIME_US * (CLOCK_HZ / `HZ_PER_MHZ),
	parameter int unsigned NORMAL_ON_CYCLES = `NORMAL_ON_TIME_US * (CLOCK_HZ / `HZ_PER_MHZ)
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_write,
	input wire logic sw_read,
	output logic [7:0] sw_rdata,
	output logic irq,
	accel_link_if.host link
);
	import accel_pkg::*;
	typedef struct packed {
		host_state_type phase;
		logic [7:0] target;
		logic [7:0] wdata;
		logic [7:0] result;
		logic reading;
		logic recovering;
		logic [2:0] step;
		logic [31:0] wait_count;
		logic [7:0] shadow_one;
		logic [7:0] shadow_four;
		logic [3:0] irq_status;
		logic [3:0] irq_mask;
		logic [7:0] sw_rdata;
		logic irq;
		logic wr;
		logic rd;
		logic pin_a_d;
		logic pin_b_d;
	} host_type;
	host_type state, next_state;
	logic [3:0] set_ev;
	logic [3:0] clr_ev;
	logic go;
	logic go_read;
	logic [7:0] go_target;
	logic [7:0] go_data;
	int unsigned rate;
	mode_type new_mode;

	always_comb
	begin
		next_state = state;
		set_ev = 4'h0;
		clr_ev = 4'h0;
		go = 1'b0;
		go_read = 1'b0;
		go_target = state.target;
		go_data = state.wdata;
		rate = rate_hz(state.shadow_one[`RATE_MSB:`RATE_LSB], state.shadow_one[`LOW_POWER_BIT]);
		new_mode = decode_mode(state.shadow_one[`LOW_POWER_BIT], state.shadow_four[`HIGH_RES_BIT]);
		next_state.wr = 1'b0;
		next_state.rd = 1'b0;

		if (sw_write)
		begin
			case (sw_addr)
				`SW_TARGET: next_state.target = sw_wdata;
				`SW_WDATA: next_state.wdata = sw_wdata;
				`SW_IRQ_MASK: next_state.irq_mask = sw_wdata[3:0];
				`SW_IRQ_STATUS: clr_ev = sw_wdata[3:0];
				`SW_COMMAND:
					if (state.phase == IDLE && !state.recovering)
					begin
						go = sw_wdata[`CMD_WRITE] | sw_wdata[`CMD_READ];
						go_read = sw_wdata[`CMD_READ];
						next_state.recovering = sw_wdata[`CMD_RECOVER] & ~go;
						next_state.step = 3'h0;
					end
				default: ;
			endcase
		end

		// Recovery walks through power-down with a filter reset in between
		if (state.phase == IDLE && state.recovering)
		begin
			go = 1'b1;
			case (state.step)
				3'h0: begin go_target = `ADDR_CONTROL_FOUR; go_data = `RECOVER_HIGH_RES; end
				3'h1: begin go_target = `ADDR_CONTROL_ONE; go_data = `RECOVER_ON; end
				3'h2: begin go_target = `ADDR_CONTROL_ONE; go_data = `RECOVER_OFF; end
				3'h3: begin go_target = `ADDR_REFERENCE; go_read = 1'b1; end
				3'h4: begin go_target = `ADDR_CONTROL_ONE; go_data = `RECOVER_ON; end
				default:
				begin
					go = 1'b0;
					next_state.recovering = 1'b0;
				end
			endcase
		end

		if (go)
		begin
			// Never let both mode bits end up set at the device
			if (!go_read && ((go_target == `ADDR_CONTROL_ONE && go_data[`LOW_POWER_BIT]
				&& state.shadow_four[`HIGH_RES_BIT]) || (go_target == `ADDR_CONTROL_FOUR
				&& go_data[`HIGH_RES_BIT] && state.shadow_one[`LOW_POWER_BIT])))
			begin
				set_ev[`EV_REFUSED] = 1'b1;
				next_state.recovering = 1'b0;
			end
			else
			begin
				next_state.target = go_target;
				next_state.wdata = go_data;
				next_state.reading = go_read;
				next_state.wr = ~go_read;
				next_state.rd = go_read;
				next_state.phase = ISSUE;
				if (!go_read && go_target == `ADDR_CONTROL_ONE)
					next_state.shadow_one = go_data;
				if (!go_read && go_target == `ADDR_CONTROL_FOUR)
					next_state.shadow_four = go_data;
			end
		end

		case (state.phase)
			IDLE: ;
			ISSUE:
				if (state.reading)
					next_state.phase = CAPTURE;
				else if (state.target == `ADDR_CONTROL_ONE && rate != 0
					&& state.shadow_one[`RATE_MSB:`RATE_LSB] != `RATE_POWER_DOWN)
				begin
					// Output is not trusted until the mode has settled
					next_state.phase = TURN_ON;
					case (new_mode)
						MODE_LOW_POWER: next_state.wait_count = 32'(LP_ON_CYCLES);
						MODE_HIGH_RES:
							next_state.wait_count = 32'(`HIGH_RES_ON_PERIODS * (CLOCK_HZ / rate));
						default: next_state.wait_count = 32'(NORMAL_ON_CYCLES);
					endcase
				end
				else
					next_state.phase = IDLE;
			CAPTURE:
			begin
				next_state.result = link.rdata;
				next_state.phase = IDLE;
			end
			TURN_ON:
				if (state.wait_count <= 32'h1)
					next_state.phase = IDLE;
				else
					next_state.wait_count = state.wait_count - 32'h1;
			default: next_state.phase = IDLE;
		endcase

		if (state.phase != IDLE && next_state.phase == IDLE)
		begin
			set_ev[`EV_DONE] = 1'b1;
			if (state.recovering)
				next_state.step = state.step + 3'h1;
		end

		next_state.pin_a_d = link.irq_pin_a;
		next_state.pin_b_d = link.irq_pin_b;
		set_ev[`EV_PIN_A] = link.irq_pin_a & ~state.pin_a_d;
		set_ev[`EV_PIN_B] = link.irq_pin_b & ~state.pin_b_d;
		// A set in the same cycle as its clear wins
		next_state.irq_status = (state.irq_status & ~clr_ev) | set_ev;
		next_state.irq = |(next_state.irq_status & next_state.irq_mask);

		next_state.sw_rdata = 8'h00;
		if (sw_read)
		begin
			case (sw_addr)
				`SW_TARGET: next_state.sw_rdata = state.target;
				`SW_WDATA: next_state.sw_rdata = state.wdata;
				`SW_RDATA: next_state.sw_rdata = state.result;
				`SW_STATUS: next_state.sw_rdata = {5'h00, state.phase == TURN_ON,
					state.recovering, state.phase != IDLE || state.recovering};
				`SW_IRQ_STATUS: next_state.sw_rdata = {4'h0, state.irq_status};
				`SW_IRQ_MASK: next_state.sw_rdata = {4'h0, state.irq_mask};
				default: next_state.sw_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= '0;
			state.phase <= IDLE;
			state.shadow_one <= `REG_RESET;
			state.shadow_four <= `REG_RESET;
		end
		else
			state <= next_state;
	end

	assign link.addr = state.target;
	assign link.wdata = state.wdata;
	assign link.wr = state.wr;
	assign link.rd = state.rd;
	assign sw_rdata = state.sw_rdata;
	assign irq = state.irq;
endmodule // accel_host
`default_nettype wire

// ===== accel_link_if.sv
// Register link between the host controller and the sensor device
`default_nettype none
interface accel_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic irq_pin_a;
	logic irq_pin_b;
	modport device (input addr, input wdata, input wr, input rd,
		output rdata, output irq_pin_a, output irq_pin_b);
	modport host (output addr, output wdata, output wr, output rd,
		input rdata, input irq_pin_a, input irq_pin_b);
endinterface
`default_nettype wire

// ===== accel_link_sva.sv
// Assertions on the register link between host controller and sensor device
`include "accel_defines.svh"
`default_nettype none
module accel_link_sva #(
	parameter int unsigned BOOT_CYCLES = `BOOT_TIME_MS * (`CLOCK_HZ / `HZ_PER_KHZ)
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic booting,
	input wire logic sampling,
	input wire logic sample_strobe,
	input wire logic filter_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned boot_count;

	// Counts the edges spent booting since the last release of reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			boot_count <= 0;
		else if (booting)
			boot_count <= boot_count + 1;
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_boot_length: assert property ($fell(booting) |->
		boot_count >= BOOT_CYCLES - 1 && boot_count <= BOOT_CYCLES + 1)
		else $error("boot phase length wrong");
	a_boot_once: assert property (!booting |=> !booting)
		else $error("boot phase came back");
	a_boot_quiet: assert property (booting |-> !sampling && !sample_strobe)
		else $error("sampling during boot");
	a_down_no_update: assert property (!sampling [*2] |-> !sample_strobe)
		else $error("outputs updated while powered down");
	a_ref_read_filter: assert property (rd && addr == 8'h26 |=> filter_reset)
		else $error("reference read did not reset filter");
	a_filter_cause: assert property (filter_reset |-> $past(rd) && $past(addr) == 8'h26)
		else $error("filter reset without reference read");
	// A plain write may be followed by the next strobe after one idle cycle
	a_strobes_apart: assert property ((wr || rd) |=> !(wr || rd))
		else $error("link strobes too close");
	a_strobes_single: assert property (!(wr && rd))
		else $error("read and write strobes together");
	a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside its cycle");
endmodule // accel_link_sva
`default_nettype wire

// ===== accel_mode_rate_control_tb.sv
// Self-checking bench joining the host controller and the sensor device
`include "accel_defines.svh"
`default_nettype none
module accel_mode_rate_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import accel_pkg::*;
	// Shortened clock keeps the slowest rate at ten thousand cycles
	localparam int unsigned CLK_HZ = 10000;
	localparam int unsigned BOOT = 20;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata;
	logic sw_write = 1'b0, sw_read = 1'b0, irq, booting, sampling, sample_strobe, filter_reset;
	logic [15:0] accel_x = 16'h0000, accel_y = 16'h0000, accel_z = 16'h0000;
	logic [15:0] raw [3];
	logic [31:0] seed = 32'he1e1;
	mode_type active_mode;
	int errors = 0, n_tests = 0, cycles = 0, fr_cnt = 0;

	accel_link_if link ();
	accel_device #(.CLOCK_HZ(CLK_HZ), .BOOT_CYCLES(BOOT)) accel_device_i (.clk(clk),
		.reset_n(reset_n), .link(link.device), .accel_x(accel_x), .accel_y(accel_y),
		.accel_z(accel_z), .booting(booting), .active_mode(active_mode), .sampling(sampling),
		.sample_strobe(sample_strobe), .filter_reset(filter_reset));
	accel_host #(.CLOCK_HZ(CLK_HZ), .LP_ON_CYCLES(10), .NORMAL_ON_CYCLES(10)) accel_host_i (
		.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata), .irq(irq), .link(link.host));
	accel_link_sva #(.BOOT_CYCLES(BOOT)) accel_link_sva_i (.clk(clk), .reset_n(reset_n),
		.addr(link.addr), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .booting(booting),
		.sampling(sampling), .sample_strobe(sample_strobe), .filter_reset(filter_reset));

	initial
	begin
		forever #20 clk = ~clk;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// A hang costs one mismatch and ends the run
	always @(posedge clk)
	begin
		cycles++;
		if (filter_reset === 1'b1)
			fr_cnt++;
		if (cycles == 60000)
		begin
			errors++;
			end_of_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int exp_period(input logic [3:0] c, input logic lp);
		int hz [10] = '{1, 1, 10, 25, 50, 100, 200, 400, 1600, 1344};
		if (c == 4'h9 && lp)
			return CLK_HZ / 5376;
		return CLK_HZ / hz[c];
	endfunction

	task automatic fail(input string m);
		errors++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_tests++;
		if (got !== exp)
			fail(m);
	endtask

	task automatic check_bit(input logic got, input logic exp, input string m);
		n_tests++;
		if (got !== exp)
			fail(m);
	endtask

	task automatic check_count(input int got, input int exp, input string m);
		n_tests++;
		if (got != exp)
			fail(m);
	endtask

	task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_write <= 1'b1;
		@(posedge clk);
		sw_write <= 1'b0;
	endtask

	task automatic sw_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_read <= 1'b1;
		@(posedge clk);
		sw_read <= 1'b0;
		#1 d = sw_rdata;
	endtask

	// Polls until no transfer, recovery or turn-on wait is pending
	task automatic wait_idle();
		logic [7:0] s;
		s = 8'hff;
		for (int i = 0; i < 20000 && s[2:0] !== 3'b000; i++)
			sw_rd(`SW_STATUS, s);
		if (s[2:0] !== 3'b000)
			fail("host stays busy");
	endtask

	task automatic dev_wr(input logic [7:0] t, input logic [7:0] d);
		sw_wr(`SW_TARGET, t);
		sw_wr(`SW_WDATA, d);
		sw_wr(`SW_COMMAND, 8'h01);
		wait_idle();
	endtask

	task automatic dev_rd(input logic [7:0] t, output logic [7:0] d);
		sw_wr(`SW_TARGET, t);
		sw_wr(`SW_COMMAND, 8'h02);
		wait_idle();
		sw_rd(`SW_RDATA, d);
	endtask

	task automatic wait_strobe(output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (sample_strobe !== 1'b1 && n < 12000);
	endtask

	task automatic new_raw();
		@(posedge clk);
		for (int a = 0; a < 3; a++)
		begin
			seed = lfsr(seed);
			raw[a] = seed[15:0];
		end
		accel_x <= raw[0];
		accel_y <= raw[1];
		accel_z <= raw[2];
	endtask

	task automatic check_outs(input logic [15:0] r [3], input logic [1:0] md, input logic [2:0] en);
		logic [7:0] d;
		logic [15:0] e;
		for (int a = 0; a < 6; a++)
		begin
			dev_rd(8'h28 + 8'(a), d);
			e = md[1] ? 16'hff00 : md[0] ? 16'hfff0 : 16'hffc0;
			e = en[a / 2] ? r[a / 2] & e : 16'h0000;
			check_byte(d, a[0] ? e[15:8] : e[7:0], "output sample");
		end
	endtask

	initial
	begin
		logic [7:0] d;
		logic [15:0] held [3];
		logic [1:0] md;
		logic [2:0] en;
		int n;
		int f0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		check_bit(booting, 1'b1, "boot start");
		repeat (BOOT + 2) @(negedge clk);
		check_bit(booting, 1'b0, "boot end");
		check_bit(sampling, 1'b0, "power-down after boot");
		sw_wr(`SW_IRQ_MASK, 8'h01);
		$display("boot test done");
		// Normal, high-resolution, low-power in turn; the two mode bits equal the mode code
		for (int k = 0; k < 3; k++)
		begin
			md = 2'(k);
			new_raw();
			en = seed[18:16] == 3'b000 ? 3'b010 : seed[18:16];
			dev_wr(`ADDR_CONTROL_FOUR, {4'h0, md[0], 3'b000});
			dev_wr(`ADDR_CONTROL_ONE, {4'h7, md[1], en});
			wait_strobe(n);
			wait_strobe(n);
			check_count(n, exp_period(4'h7, md[1]), "rate 7");
			check_byte({6'h00, active_mode}, {6'h00, md}, "mode");
			check_outs(raw, md, en);
		end
		$display("mode test done");
		for (int c = 1; c < 10; c++)
		begin
			dev_wr(`ADDR_CONTROL_ONE, {4'(c), 4'hf});
			wait_strobe(n);
			wait_strobe(n);
			check_count(n, exp_period(4'(c), 1'b1), "low-power rate");
		end
		dev_wr(`ADDR_CONTROL_ONE, 8'h97);
		wait_strobe(n);
		wait_strobe(n);
		check_count(n, exp_period(4'h9, 1'b0), "normal fast rate");
		dev_wr(`ADDR_CONTROL_ONE, 8'h87);
		repeat (40) @(negedge clk);
		check_bit(sampling, 1'b0, "code 8 outside low-power");
		$display("rate test done");
		dev_wr(`ADDR_CONTROL_ONE, 8'h57);
		wait_strobe(n);
		dev_wr(`ADDR_CONTROL_ONE, 8'h07);
		held = raw;
		new_raw();
		repeat (300) @(negedge clk);
		check_bit(sampling, 1'b0, "power-down");
		check_outs(held, 2'b00, 3'b111);
		dev_rd(`ADDR_CONTROL_ONE, d);
		check_byte(d, 8'h07, "config kept");
		$display("power-down test done");
		// Host must refuse the combination with both mode bits set
		dev_wr(`ADDR_CONTROL_FOUR, 8'h08);
		dev_wr(`ADDR_CONTROL_ONE, 8'h5f);
		sw_rd(`SW_IRQ_STATUS, d);
		check_bit(d[`EV_REFUSED], 1'b1, "refusal event");
		dev_rd(`ADDR_CONTROL_ONE, d);
		check_byte(d, 8'h07, "refused write");
		check_bit(irq, 1'b1, "irq raised");
		sw_wr(`SW_IRQ_MASK, 8'h00);
		repeat (2) @(negedge clk);
		check_bit(irq, 1'b0, "irq masked");
		sw_wr(`SW_IRQ_STATUS, 8'hff);
		sw_rd(`SW_IRQ_STATUS, d);
		check_byte(d, 8'h00, "irq cleared");
		$display("refusal test done");
		f0 = fr_cnt;
		sw_wr(`SW_COMMAND, 8'h04);
		wait_idle();
		check_count(fr_cnt - f0, 1, "recovery filter reset");
		dev_rd(`ADDR_CONTROL_ONE, d);
		check_byte(d, 8'h57, "recovery rate");
		check_byte({6'h00, active_mode}, 8'h01, "recovery mode");
		// Rewriting the same rate restarts the seven-period high-resolution wait
		sw_wr(`SW_WDATA, `RECOVER_ON);
		sw_wr(`SW_COMMAND, 8'h01);
		repeat (`HIGH_RES_ON_PERIODS * exp_period(4'h5, 1'b0) - 100) @(negedge clk);
		sw_rd(`SW_STATUS, d);
		check_bit(d[2], 1'b1, "turn-on wait held");
		repeat (200) @(negedge clk);
		sw_rd(`SW_STATUS, d);
		check_bit(d[2], 1'b0, "turn-on wait ended");
		$display("recovery test done");
		dev_wr(`ADDR_CONTROL_THREE, 8'h40);
		dev_wr(`ADDR_IRQ_GEN_A, 8'h02);
		@(posedge clk);
		accel_x <= 16'h4000;
		wait_strobe(n);
		wait_strobe(n);
		check_bit(link.irq_pin_a, 1'b1, "pin a routed");
		check_bit(link.irq_pin_b, 1'b0, "pin b idle");
		dev_wr(`ADDR_CONTROL_SIX, 8'h02);
		wait_strobe(n);
		wait_strobe(n);
		check_bit(link.irq_pin_a, 1'b0, "pin a inverted");
		check_bit(link.irq_pin_b, 1'b1, "pin b inverted");
		$display("interrupt pin test done");
		end_of_test();
	end
endmodule // accel_mode_rate_control_tb
`default_nettype wire

// ===== accel_pkg.sv
// Types and decode helpers shared by both ends
`default_nettype none
package accel_pkg;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_HIGH_RES, MODE_LOW_POWER, MODE_FORBIDDEN} mode_type;
	typedef enum logic [1:0] {BOOTING, POWERED_DOWN, SAMPLING} dev_state_type;
	typedef enum logic [1:0] {IDLE, ISSUE, CAPTURE, TURN_ON} host_state_type;

	function automatic mode_type decode_mode(input logic lp, input logic high_res);
		return mode_type'({lp, high_res});
	endfunction

	// Zero means no sampling at this code in this mode
	function automatic int unsigned rate_hz(input logic [3:0] code, input logic lp);
		case (code)
			4'h1: return 1;
			4'h2: return 10;
			4'h3: return 25;
			4'h4: return 50;
			4'h5: return 100;
			4'h6: return 200;
			4'h7: return 400;
			4'h8: return lp ? 1600 : 0;
			4'h9: return lp ? 5376 : 1344;
			default: return 0;
		endcase
	endfunction

	function automatic logic [15:0] sample_mask(input mode_type mode);
		case (mode)
			MODE_LOW_POWER: return 16'hff00;
			MODE_HIGH_RES: return 16'hfff0;
			default: return 16'hffc0;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== rate_ticker.sv
// Sample-rate tick generator
`include "accel_defines.svh"
`default_nettype none
module rate_ticker #(
	parameter int unsigned CLOCK_HZ = `CLOCK_HZ
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [3:0] rate_code,
	input wire logic low_power,
	output logic tick
);
	import accel_pkg::*;
	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} ticker_type;
	ticker_type state, next_state;
	int unsigned rate;
	logic [31:0] period;

	always_comb
	begin
		rate = rate_hz(rate_code, low_power);
		period = (rate == 0) ? 32'h0 : 32'(CLOCK_HZ / rate);
		next_state = state;
		next_state.tick = 1'b0;
		if (!run || period == 32'h0)
			next_state.count = 32'h0;
		else if (state.count >= period - 32'h1)
		begin
			next_state.count = 32'h0;
			next_state.tick = 1'b1;
		end
		else
			next_state.count = state.count + 32'h1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign tick = state.tick;
endmodule // rate_ticker
`default_nettype wire
